// ==== rtl/adc_pipe_pkg.sv ====
// Shared constants for the pipelined converter output interface.
package adc_pipe_pkg;
	// ------------------------------------------------------------
	// Word and pipeline geometry
	// ------------------------------------------------------------
	localparam int ADC_BITS = 12;
	localparam int STAGE_COUNT = 11;
	localparam int CODE_W = 2;
	localparam int RES_W = 14;
	localparam int SUM_W = 15;
	localparam int TOP_BIT = ADC_BITS - 1;
	// Half-clock steps from the sampling rise to the output update.
	localparam int LATENCY_STEPS = 13;

	// ------------------------------------------------------------
	// Residue arithmetic, in output LSB units
	// ------------------------------------------------------------
	localparam logic signed [RES_W-1:0] MID_SCALE = 14'sh0800;
	localparam logic signed [RES_W-1:0] FULL_SCALE = 14'sh1000;
	localparam logic signed [RES_W-1:0] THRESH_HI = 14'sh0400;
	localparam logic signed [RES_W-1:0] THRESH_LO = -14'sh0400;
	localparam logic signed [SUM_W-1:0] SUM_OFFSET = 15'sh0800;

	// ------------------------------------------------------------
	// Stage decision codes (the fourth code is the redundant one)
	// ------------------------------------------------------------
	localparam logic [CODE_W-1:0] CODE_LOW = 2'h0;
	localparam logic [CODE_W-1:0] CODE_MID = 2'h1;
	localparam logic [CODE_W-1:0] CODE_HIGH = 2'h2;
	localparam logic [CODE_W-1:0] CODE_UNUSED = 2'h3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [ADC_BITS-1:0] WORD_RST = 12'h000;
	localparam logic signed [RES_W-1:0] RES_RST = 14'sh0000;
endpackage : adc_pipe_pkg

// ==== rtl/code_delay.sv ====
// Step-clocked delay line that aligns one stage code.
module code_delay #(
	parameter int DEPTH = 1,
	parameter int W = 2
) (
	input wire logic i_clk, // System clock.
	input wire logic i_nrst, // Synchronous reset, active low.
	input wire logic i_step, // Half-clock step pulse.
	input wire logic [W-1:0] i_code, // Code from the stage.
	output logic [W-1:0] o_code // Code delayed by DEPTH steps.
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] line;
	} state_t;

	state_t st_q;
	state_t st_d;

	// The line shifts only on a step, so it tracks the pipeline.
	always_comb begin
		st_d = st_q;
		if (i_step) begin
			st_d.line[0] = i_code;
			for (int j = 1; j < DEPTH; j++) begin
				st_d.line[j] = st_q.line[j-1];
			end
		end
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_code = st_q.line[DEPTH-1];

	a_line_holds: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!i_step |=> o_code == $past(o_code))
		else $error("delay line moved without a step");
endmodule : code_delay

// ==== rtl/adc_stage.sv ====
// One pipeline stage: two-bit quantizer and two-bit feedback converter.
module adc_stage (
	input wire logic i_clk, // System clock.
	input wire logic i_nrst, // Synchronous reset, active low.
	input wire logic i_step, // Half-clock step pulse.
	input wire logic signed [adc_pipe_pkg::RES_W-1:0] i_res, // Residue in.
	output logic signed [adc_pipe_pkg::RES_W-1:0] o_res, // Residue out.
	output logic [adc_pipe_pkg::CODE_W-1:0] o_code // Stage decision.
);
	typedef struct packed {
		logic signed [adc_pipe_pkg::RES_W-1:0] res;
		logic [adc_pipe_pkg::CODE_W-1:0] code;
	} state_t;

	state_t st_q;
	state_t st_d;

	// Quantize against two thresholds, subtract the feedback level and
	// double. The overlap keeps every residue inside half full scale.
	always_comb begin
		st_d = st_q;
		if (i_step) begin
			if (i_res >= adc_pipe_pkg::THRESH_HI) begin
				st_d.code = adc_pipe_pkg::CODE_HIGH;
				st_d.res = (i_res <<< 1) - adc_pipe_pkg::FULL_SCALE;
			end else if (i_res < adc_pipe_pkg::THRESH_LO) begin
				st_d.code = adc_pipe_pkg::CODE_LOW;
				st_d.res = (i_res <<< 1) + adc_pipe_pkg::FULL_SCALE;
			end else begin
				st_d.code = adc_pipe_pkg::CODE_MID;
				st_d.res = i_res <<< 1;
			end
		end
	end

	// State register.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			st_q <= '{res: adc_pipe_pkg::RES_RST, code: adc_pipe_pkg::CODE_MID};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_res = st_q.res;
	assign o_code = st_q.code;

	a_stage_code: assert property (@(posedge i_clk) disable iff (!i_nrst)
		o_code != adc_pipe_pkg::CODE_UNUSED)
		else $error("stage produced the unused code");
	a_stage_step: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(o_res != $past(o_res)) |-> $past(i_step))
		else $error("stage residue changed without a step");
endmodule : adc_stage

// ==== rtl/adc_out_if.sv ====
// Top of the pipelined converter: sampling, stages, alignment, output.

// Functional notes
// - Output word appears 6.5 convert clocks after its sampling rising edge.
// - Eleven stages, each with a two-bit quantizer and feedback converter.
// - Stages step twice per convert clock, once on each of its edges.
// - Both rising and falling convert clock edges advance the pipeline.
// - Each stage code except the last passes its own delay line before error correction.
// - Each result leaves as one parallel twelve-bit word.
// - Select low gives straight offset binary; full scale reads all ones.
// - Select high gives two's complement by inverting only the top bit.
// - Disable high drops O_DATA_OE; O_DATA still takes each new word.
// - Disable low drives the data outputs normally.
// - Pin bit one carries the top bit, pin bit twelve the bottom bit.
module adc_out_if (
	input wire logic I_SYS_CLK, // System clock, 200 MHz.
	input wire logic I_NRST, // Synchronous reset, active low.
	input wire logic I_CONV_CLK, // Convert clock, sampled as a level.
	input wire logic [11:0] I_ANALOG, // Ideal input level, offset code.
	input wire logic I_TOP_BIT_INVERT_SELECT, // High: two's complement.
	input wire logic I_OUT_DISABLE, // High: data outputs released.
	output logic [11:0] O_DATA, // Bit 11 is data_bit_top, 0 bottom.
	output logic O_DATA_OE, // High while the data pins are driven.
	output logic O_WORD_STROBE // One-cycle pulse on a new word.
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic conv_prev;
		logic signed [adc_pipe_pkg::RES_W-1:0] held;
		logic [adc_pipe_pkg::ADC_BITS-1:0] corr;
		logic [adc_pipe_pkg::LATENCY_STEPS-1:0] valid;
		logic [adc_pipe_pkg::ADC_BITS-1:0] data;
		logic oe;
		logic strobe;
	} state_t;

	state_t st_q;
	state_t st_d;

	logic rise;
	logic fall;
	logic step;
	logic signed [adc_pipe_pkg::RES_W-1:0] res [adc_pipe_pkg::STAGE_COUNT+1];
	logic [adc_pipe_pkg::CODE_W-1:0] code [adc_pipe_pkg::STAGE_COUNT];
	logic [adc_pipe_pkg::CODE_W-1:0] aligned [adc_pipe_pkg::STAGE_COUNT];
	logic signed [adc_pipe_pkg::SUM_W-1:0] sum;
	logic [adc_pipe_pkg::ADC_BITS-1:0] fixed_word;

	// ------------------------------------------------------------
	// Convert clock edges
	// ------------------------------------------------------------
	// Each edge of the convert clock is one half-clock step.
	assign rise = I_CONV_CLK & ~st_q.conv_prev;
	assign fall = ~I_CONV_CLK & st_q.conv_prev;
	assign step = rise | fall;

	// ------------------------------------------------------------
	// Quantizer pipeline
	// ------------------------------------------------------------
	// The held sample feeds the first stage; each residue feeds the next.
	assign res[0] = st_q.held;

	genvar gi;
	generate
		for (gi = 0; gi < adc_pipe_pkg::STAGE_COUNT; gi++) begin : g_stage
			adc_stage u_stage (
				.i_clk(I_SYS_CLK),
				.i_nrst(I_NRST),
				.i_step(step),
				.i_res(res[gi]),
				.o_res(res[gi+1]),
				.o_code(code[gi])
			);
			// Earlier stages wait longer so all codes meet together.
			if (gi < adc_pipe_pkg::STAGE_COUNT - 1) begin : g_delay
				code_delay #(
					.DEPTH(adc_pipe_pkg::STAGE_COUNT - 1 - gi),
					.W(adc_pipe_pkg::CODE_W)
				) u_delay (
					.i_clk(I_SYS_CLK),
					.i_nrst(I_NRST),
					.i_step(step),
					.i_code(code[gi]),
					.o_code(aligned[gi])
				);
			end else begin : g_last
				assign aligned[gi] = code[gi];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Digital error correction
	// ------------------------------------------------------------
	// Overlapping stage codes are added with one-bit shifts between
	// neighbours; the final residue sign settles the bottom bit.
	always_comb begin
		sum = '0;
		for (int k = 0; k < adc_pipe_pkg::STAGE_COUNT; k++) begin
			sum = sum + ((adc_pipe_pkg::SUM_W'(aligned[k]) - 15'sh0001)
				<<< (adc_pipe_pkg::STAGE_COUNT - k));
		end
		if (res[adc_pipe_pkg::STAGE_COUNT] < 0) begin
			sum = sum - 15'sh0001;
		end
		sum = sum + adc_pipe_pkg::SUM_OFFSET;
		fixed_word = sum[adc_pipe_pkg::ADC_BITS-1:0];
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Sample on a rise, shift on every step, and load the output on the
	// falling step thirteen steps after the sampling rise.
	always_comb begin
		st_d = st_q;
		st_d.conv_prev = I_CONV_CLK;
		st_d.strobe = 1'b0;
		st_d.oe = ~I_OUT_DISABLE;
		if (rise) begin
			st_d.held = $signed({2'b00, I_ANALOG}) - adc_pipe_pkg::MID_SCALE;
		end
		if (step) begin
			st_d.corr = fixed_word;
			st_d.valid = {st_q.valid[adc_pipe_pkg::LATENCY_STEPS-2:0], rise};
		end
		if (fall && st_q.valid[adc_pipe_pkg::LATENCY_STEPS-1]) begin
			st_d.data = st_q.corr;
			st_d.data[adc_pipe_pkg::TOP_BIT] =
				st_q.corr[adc_pipe_pkg::TOP_BIT] ^ I_TOP_BIT_INVERT_SELECT;
			st_d.strobe = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			st_q <= '{conv_prev: 1'b0, held: adc_pipe_pkg::RES_RST,
				corr: adc_pipe_pkg::WORD_RST, valid: '0,
				data: adc_pipe_pkg::WORD_RST, oe: 1'b0, strobe: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs come straight from the state register.
	assign O_DATA = st_q.data;
	assign O_DATA_OE = st_q.oe;
	assign O_WORD_STROBE = st_q.strobe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_word_on_fall: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		O_WORD_STROBE |-> $past(fall)
			&& $past(st_q.valid[adc_pipe_pkg::LATENCY_STEPS-1]))
		else $error("word delivered off the latency step");
	a_data_moves: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		(O_DATA != $past(O_DATA)) |-> O_WORD_STROBE)
		else $error("data changed without a word strobe");
	a_strobe_single: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		O_WORD_STROBE |=> !O_WORD_STROBE)
		else $error("word strobe longer than one cycle");
	a_low_bits: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		O_WORD_STROBE |-> O_DATA[10:0] == $past(st_q.corr[10:0]))
		else $error("low bits differ from corrected word");
	a_top_coding: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		O_WORD_STROBE |-> O_DATA[11] ==
			($past(st_q.corr[11]) ^ $past(I_TOP_BIT_INVERT_SELECT)))
		else $error("top bit coding wrong");
	a_oe_follows: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		$past(I_NRST) |-> O_DATA_OE == !$past(I_OUT_DISABLE))
		else $error("output enable does not follow disable");
	a_edge_step: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		(I_CONV_CLK != st_q.conv_prev) |=> (st_q.valid[0] == $past(rise))
			|| $past(!step))
		else $error("convert edge did not advance the pipeline");
	a_hold_steady: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
		!step |=> st_q.valid == $past(st_q.valid))
		else $error("pipeline advanced without an edge");

	// Rises and falls alternate, so two samples never sit in neighbouring
	// steps of the valid chain.
	a_rise_fall_alt: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_NRST)
		(st_q.valid & (st_q.valid >> 1)) == '0)
		else $error("two sampling rises in neighbouring steps");
	// The overlap must keep the last residue inside half full scale, or
	// the bottom bit decision would be wrong.
	a_residue_bound: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_NRST)
		res[adc_pipe_pkg::STAGE_COUNT] >= -adc_pipe_pkg::MID_SCALE
			&& res[adc_pipe_pkg::STAGE_COUNT] < adc_pipe_pkg::MID_SCALE)
		else $error("final residue outside half full scale");
	// Straight coding passes the corrected word through untouched.
	a_straight_word: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_NRST)
		O_WORD_STROBE && !$past(I_TOP_BIT_INVERT_SELECT)
			|-> O_DATA == $past(st_q.corr))
		else $error("straight coding altered the word");
	// Two's complement inverts the top bit and keeps all others.
	a_twos_word: assert property (@(posedge I_SYS_CLK)
		disable iff (!I_NRST)
		O_WORD_STROBE && $past(I_TOP_BIT_INVERT_SELECT)
			|-> O_DATA == {~$past(st_q.corr[11]), $past(st_q.corr[10:0])})
		else $error("two's complement coding wrong");
endmodule : adc_out_if

// ==== verification/conv_partner.sv ====
// Convert clock source and data pin resolver beside the converter.
module conv_partner (
	input wire logic i_clk, // System clock.
	input wire logic i_run, // High lets the convert clock run.
	input wire logic [11:0] i_first, // Level taken at the first rise.
	input wire logic [11:0] i_step, // Level change per convert cycle.
	input wire logic [11:0] i_data, // Word from the converter.
	input wire logic i_oe, // High while the converter drives the pins.
	output logic o_conv_clk, // Convert clock, stands low when stopped.
	output logic [11:0] o_analog, // Level to be converted.
	output logic [11:0] o_pins // Resolved level of the data pins.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] half_cnt;

	// Start with the clock low and the level at zero.
	initial begin
		o_conv_clk = 1'h0;
		half_cnt = 2'h0;
		o_analog = 12'h000;
	end

	// Halves of four system cycles; a started cycle always ends low.
	always @(negedge i_clk) begin
		if (i_run || o_conv_clk) begin
			half_cnt <= half_cnt + 2'h1;
			if (half_cnt == 2'h3) begin
				o_conv_clk <= ~o_conv_clk;
				if (o_conv_clk) begin
					o_analog <= o_analog + i_step;
				end
			end
		end else begin
			o_analog <= i_first;
		end
	end

	// Released pins show the inverse so a stale word cannot pass.
	assign o_pins = i_oe ? i_data : ~i_data;
endmodule : conv_partner

// ==== verification/tb.sv ====
// Self-checking testbench for the pipelined converter output interface.
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, nrst, run, sel, dis, conv_clk, oe, strobe;
	logic [11:0] first, step, analog, data_out, pins, exp_w;
	logic conv_p, sel_p, dis_p, nrst_p;
	int errors, cmp_count, words, cyc, chg, last_chg;
	int rise_c[$];
	logic [11:0] rise_v[$];

	adc_out_if adc_out_if_i (
		.I_SYS_CLK(sys_clk), .I_NRST(nrst), .I_CONV_CLK(conv_clk),
		.I_ANALOG(analog), .I_TOP_BIT_INVERT_SELECT(sel),
		.I_OUT_DISABLE(dis), .O_DATA(data_out), .O_DATA_OE(oe),
		.O_WORD_STROBE(strobe));
	conv_partner conv_partner_i (
		.i_clk(sys_clk), .i_run(run), .i_first(first), .i_step(step),
		.i_data(data_out), .i_oe(oe), .o_conv_clk(conv_clk),
		.o_analog(analog), .o_pins(pins));

	// System clock of 5 ns.
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// -----------------------------------------------------------------
	// Checking and closing
	// -----------------------------------------------------------------
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	// Pairs each word with its sampling rise and watches the pin enable.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 1) begin
			check({11'h000, oe}, {11'h000, nrst_p & ~dis_p});
			if (!nrst_p) begin
				check(data_out, 12'h000);
				check({11'h000, strobe}, 12'h000);
			end
		end
		if (strobe) begin
			words++;
			check(12'(rise_c.size() != 0), 12'h001);
			if (rise_c.size() != 0) begin
				exp_w = rise_v.pop_front();
				exp_w[adc_pipe_pkg::TOP_BIT] ^= sel_p;
				check(data_out, exp_w);
				check(12'(chg - rise_c.pop_front()), 12'h00D);
				check(12'(cyc - last_chg), 12'h001);
				if (oe) begin
					check(pins, exp_w);
				end
			end
		end
		if (!nrst) begin
			conv_p = 1'h0;
			rise_c.delete();
			rise_v.delete();
		end else if (conv_clk != conv_p) begin
			chg++;
			last_chg = cyc;
			if (conv_clk) begin
				rise_c.push_back(chg);
				rise_v.push_back(analog);
			end
			conv_p = conv_clk;
		end
		sel_p = sel;
		dis_p = dis;
		nrst_p = nrst;
	end

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	// Runs a number of whole convert cycles, then counts the words seen.
	task automatic run_span(input int n_conv, input int n_words);
		int w0;
		w0 = words;
		run <= 1'h1;
		repeat (n_conv * 8) @(negedge sys_clk);
		run <= 1'h0;
		repeat (4) @(negedge sys_clk);
		check(12'(words - w0), 12'(n_words));
	endtask : run_span

	// Only two of the eight words leave; the other six wait in the pipeline for the next span.
	task automatic t_fill();
		first <= 12'h000;
		step <= 12'h2AB;
		run_span(8, 2);
	endtask : t_fill

	// Both codings across the mid-scale and full-scale wrap points.
	task automatic t_codes();
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 2; k++) begin
				sel <= s[0];
				first <= (k == 0) ? 12'h7FE : 12'hFFE;
				step <= 12'h001;
				@(negedge sys_clk);
				run_span(8, 8);
			end
		end
		sel <= 1'h0;
	endtask : t_codes

	// Disable changes only while the convert clock stands still.
	task automatic t_disable();
		dis <= 1'h1;
		first <= 12'h123;
		step <= 12'hF0F;
		@(negedge sys_clk);
		run_span(8, 8);
		check({11'h000, oe}, 12'h000);
		dis <= 1'h0;
		run_span(8, 8);
		check({11'h000, oe}, 12'h001);
	endtask : t_disable

	// Reset in mid-run clears the outputs, then words flow again.
	task automatic t_reset();
		int w0;
		run <= 1'h1;
		repeat (37) @(negedge sys_clk);
		nrst <= 1'h0;
		repeat (4) @(negedge sys_clk);
		check(data_out, 12'h000);
		nrst <= 1'h1;
		w0 = words;
		repeat (128) @(negedge sys_clk);
		run <= 1'h0;
		repeat (12) @(negedge sys_clk);
		check(12'(words > w0), 12'h001);
	endtask : t_reset

	// Main sequence.
	initial begin
		nrst = 1'h0;
		run = 1'h0;
		sel = 1'h0;
		dis = 1'h0;
		first = 12'h000;
		step = 12'h000;
		{errors, cmp_count, words, cyc, chg, last_chg} = '0;
		{conv_p, sel_p, dis_p, nrst_p} = 4'h0;
		repeat (16) @(negedge sys_clk);
		nrst <= 1'h1;
		repeat (4) @(negedge sys_clk);
		t_fill();
		t_codes();
		t_disable();
		t_reset();
		conclude();
	end

	// Watchdog well beyond the roughly 700 cycles the scenarios take.
	initial begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		$display("ERROR at %0t: run did not finish", $time);
		conclude();
	end
endmodule : tb
